/* File: flash_cfg_pkg.sv */
// Types shared by the flash driver config bank
package flash_cfg_pkg;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_ADDR      = 4'b0001,
        ST_ADDR_ACK  = 4'b0010,
        ST_PTR       = 4'b0011,
        ST_PTR_ACK   = 4'b0100,
        ST_WDATA     = 4'b0101,
        ST_WDATA_ACK = 4'b0110,
        ST_RDATA     = 4'b0111,
        ST_RACK      = 4'b1000
    } serial_state_e;

endpackage

/* File: flash_cfg_regs.svh */
// Register offsets, field positions, reset values and timing figures of the flash driver config bank
`ifndef FLASH_CFG_REGS_SVH
`define FLASH_CFG_REGS_SVH

`define SLAVE_ADDRESS          7'h30
`define REG_CHIP_IDENTITY      8'h00
`define REG_REVISION_INFO      8'h01
`define REG_IND_TIMEOUT_CFG    8'h02
`define CFG_RESET_VALUE        8'h0F
`define TIMEOUT_LSB            0
`define TIMEOUT_MSB            3
`define THRESHOLD_LSB          4
`define THRESHOLD_MSB          5
`define IND_CURRENT_LSB        6
`define IND_CURRENT_MSB        7
`define CLOCK_HZ               25000000
`define CYCLES_PER_MS          (`CLOCK_HZ / 1000)
`define TIMEOUT_BASE_MS        100
`define TIMEOUT_STEP_MS        50
`define TIMEOUT_BASE_CYCLES    (`TIMEOUT_BASE_MS * `CYCLES_PER_MS)
`define TIMEOUT_STEP_CYCLES    (`TIMEOUT_STEP_MS * `CYCLES_PER_MS)

`endif

/* File: flash_driver_config_regs.sv */
// Two-wire serial slave with the identity, revision and indicator/timeout config registers
//
// Summary of operation
// - Address 0 reads a fixed identity byte
// - Address 1 reads revision, upper nibble zero
// - Address 2 is a read/write config register
// - Bits 3:0 timeout code, 100ms+50ms/step, reset Fh
// - Bits 5:4 pick LED count threshold, reset 00
// - Bits 7:6 pick indicator current, reset 00
// - Slave address 0110000, direction bit last
// - Register pointer advances after each data byte
// - Flash ends by the coded timeout
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg_regs.svh"
module flash_driver_config_regs #(
    parameter int       P_TIMEOUT_BASE_CYCLES = `TIMEOUT_BASE_CYCLES,
    parameter int       P_TIMEOUT_STEP_CYCLES = `TIMEOUT_STEP_CYCLES,
    parameter logic [7:0] P_CHIP_IDENTITY_VALUE = 8'hA5, // Arbitrary value
    parameter logic [3:0] P_REVISION            = 4'h1   // Arbitrary value
) (
    input  wire logic       i_clock,
    input  wire logic       i_rstn,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    input  wire logic       i_strobe,
    input  wire logic       i_flash_request,
    output logic            o_flash_on,
    output logic            o_flash_expired,
    output logic [3:0]      o_flash_timeout_code,
    output logic [1:0]      o_led_count_threshold_voltage_sel,
    output logic [1:0]      o_indicator_current_sel
);
    import flash_cfg_pkg::*;

    // ----------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------
    logic [1:0] rst_sync_q;
    logic       rstn;
    logic [2:0] meta_q, mid_q, last_q, filt_q, prev_q, filt_d;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rstn = rst_sync_q[1];

    // Bit 2 strobe, bit 1 scl, bit 0 sda; a change counts once stages two and three agree
    assign filt_d = (~(mid_q ^ last_q) & mid_q) | ((mid_q ^ last_q) & filt_q);

    always_ff @(posedge i_clock or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 3'h3;
            mid_q  <= 3'h3;
            last_q <= 3'h3;
            filt_q <= 3'h3;
            prev_q <= 3'h3;
        end else begin
            meta_q <= {i_strobe, i_scl, i_sda};
            mid_q  <= meta_q;
            last_q <= mid_q;
            filt_q <= filt_d;
            prev_q <= filt_q;
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop, sda_f;
    assign sda_f     = filt_q[0];
    assign scl_rise  = filt_q[1] & ~prev_q[1];
    assign scl_fall  = ~filt_q[1] & prev_q[1];
    assign bus_start = filt_q[1] & prev_q[1] & prev_q[0] & ~filt_q[0];
    assign bus_stop  = filt_q[1] & prev_q[1] & ~prev_q[0] & filt_q[0];

    // ----------------------------------------
    // Serial slave and register bank
    // ----------------------------------------
    serial_state_e state_q, state_d;
    logic [3:0]    bitcnt_q, bitcnt_d;
    logic [7:0]    shift_q, shift_d, tx_q, tx_d, ptr_q, ptr_d, cfg_q, cfg_d;
    logic          rw_q, rw_d, sda_oe_q, sda_oe_d;

    function automatic logic [7:0] reg_read(input logic [7:0] addr, input logic [7:0] cfg);
        unique case (addr)
            `REG_CHIP_IDENTITY:   reg_read = P_CHIP_IDENTITY_VALUE;
            `REG_REVISION_INFO:   reg_read = {4'h0, P_REVISION};
            `REG_IND_TIMEOUT_CFG: reg_read = cfg;
            default:              reg_read = 8'h00;
        endcase
    endfunction

    always_comb begin
        state_d  = state_q;
        bitcnt_d = bitcnt_q;
        shift_d  = shift_q;
        tx_d     = tx_q;
        ptr_d    = ptr_q;
        rw_d     = rw_q;
        cfg_d    = cfg_q;
        if (bus_stop) begin
            state_d = ST_IDLE;
        end else if (bus_start) begin
            state_d  = ST_ADDR;
            bitcnt_d = 4'h0;
        end else if (scl_rise) begin
            if (state_q == ST_ADDR || state_q == ST_PTR || state_q == ST_WDATA) begin
                shift_d  = {shift_q[6:0], sda_f};
                bitcnt_d = bitcnt_q + 4'h1;
            end else if (state_q == ST_RDATA) begin
                bitcnt_d = bitcnt_q + 4'h1;
            end else if (state_q == ST_RACK) begin
                shift_d[0] = sda_f;
            end
        end else if (scl_fall) begin
            unique case (state_q)
                ST_ADDR: if (bitcnt_q == 4'h8) begin
                    if (shift_q[7:1] == `SLAVE_ADDRESS) begin
                        state_d = ST_ADDR_ACK;
                        rw_d    = shift_q[0];
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    bitcnt_d = 4'h0;
                    if (rw_q) begin
                        state_d = ST_RDATA;
                        tx_d    = reg_read(ptr_q, cfg_q);
                    end else begin
                        state_d = ST_PTR;
                    end
                end
                ST_PTR: if (bitcnt_q == 4'h8) begin
                    ptr_d   = shift_q;
                    state_d = ST_PTR_ACK;
                end
                ST_WDATA: if (bitcnt_q == 4'h8) begin
                    if (ptr_q == `REG_IND_TIMEOUT_CFG) begin
                        cfg_d = shift_q;
                    end
                    ptr_d   = ptr_q + 8'h01;
                    state_d = ST_WDATA_ACK;
                end
                ST_PTR_ACK, ST_WDATA_ACK: begin
                    state_d  = ST_WDATA;
                    bitcnt_d = 4'h0;
                end
                ST_RDATA: begin
                    if (bitcnt_q == 4'h8) begin
                        ptr_d   = ptr_q + 8'h01;
                        state_d = ST_RACK;
                    end else begin
                        tx_d = {tx_q[6:0], 1'b1};
                    end
                end
                ST_RACK: begin
                    if (!shift_q[0]) begin
                        state_d  = ST_RDATA;
                        bitcnt_d = 4'h0;
                        tx_d     = reg_read(ptr_q, cfg_q);
                    end else begin
                        state_d = ST_IDLE;
                    end
                end
                ST_IDLE: state_d = ST_IDLE;
                default: state_d = ST_IDLE;
            endcase
        end
        sda_oe_d = (state_d == ST_ADDR_ACK) || (state_d == ST_PTR_ACK) || (state_d == ST_WDATA_ACK)
                   || ((state_d == ST_RDATA) && !tx_d[7]);
    end

    always_ff @(posedge i_clock or negedge rstn) begin
        if (!rstn) begin
            state_q  <= ST_IDLE;
            bitcnt_q <= 4'h0;
            shift_q  <= 8'h00;
            tx_q     <= 8'hFF;
            ptr_q    <= 8'h00;
            rw_q     <= 1'b0;
            cfg_q    <= `CFG_RESET_VALUE;
            sda_oe_q <= 1'b0;
        end else begin
            state_q  <= state_d;
            bitcnt_q <= bitcnt_d;
            shift_q  <= shift_d;
            tx_q     <= tx_d;
            ptr_q    <= ptr_d;
            rw_q     <= rw_d;
            cfg_q    <= cfg_d;
            sda_oe_q <= sda_oe_d;
        end
    end

    assign o_sda_out = 1'b0;
    assign o_sda_oe  = sda_oe_q;
    assign o_flash_timeout_code              = cfg_q[`TIMEOUT_MSB:`TIMEOUT_LSB];
    assign o_led_count_threshold_voltage_sel = cfg_q[`THRESHOLD_MSB:`THRESHOLD_LSB];
    assign o_indicator_current_sel           = cfg_q[`IND_CURRENT_MSB:`IND_CURRENT_LSB];

    // ----------------------------------------
    // Flash timeout timer
    // ----------------------------------------
    flash_timer_if tif ();
    assign tif.timeout_code = cfg_q[`TIMEOUT_MSB:`TIMEOUT_LSB];
    assign tif.trigger      = i_flash_request | filt_q[2];
    assign o_flash_on       = tif.flash_on;
    assign o_flash_expired  = tif.expired;

    flash_timeout_timer #(
        .P_BASE_CYCLES (P_TIMEOUT_BASE_CYCLES),
        .P_STEP_CYCLES (P_TIMEOUT_STEP_CYCLES)
    ) u_timer (
        .i_clock (i_clock),
        .i_rstn  (rstn),
        .tif     (tif.timer)
    );

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!rstn);

    logic data_end, load_rd;
    assign data_end = scl_fall && !bus_start && !bus_stop && bitcnt_q == 4'h8;
    assign load_rd  = scl_fall && !bus_start && !bus_stop && state_q == ST_ADDR_ACK && rw_q;

    identity_read_a: assert property ((load_rd && ptr_q == 8'h00) |=> tx_q == P_CHIP_IDENTITY_VALUE)
        else $error("Identity byte wrong");
    revision_read_a: assert property ((load_rd && ptr_q == 8'h01) |=> tx_q[7:4] == 4'h0)
        else $error("Revision upper nibble not zero");
    cfg_write_a: assert property ((data_end && state_q == ST_WDATA && ptr_q == 8'h02)
                                  |=> cfg_q == $past(shift_q))
        else $error("Config write lost");
    timeout_field_a: assert property ((data_end && state_q == ST_WDATA && ptr_q == 8'h02)
                                      |=> ##1 tif.timeout_code == $past(shift_q[3:0], 2))
        else $error("Timeout code not passed to timer");
    threshold_field_a: assert property ($changed(o_led_count_threshold_voltage_sel)
                                        |-> $past(state_q) == ST_WDATA && $past(ptr_q) == 8'h02)
        else $error("Threshold changed without write");
    indicator_field_a: assert property ($changed(o_indicator_current_sel)
                                        |-> $past(state_q) == ST_WDATA && $past(data_end))
        else $error("Indicator current changed without write");
    addr_reject_a: assert property ((data_end && state_q == ST_ADDR && shift_q[7:1] != 7'h30)
                                    |=> state_q == ST_IDLE && !o_sda_oe)
        else $error("Foreign address acknowledged");
    ptr_advance_a: assert property ((data_end && (state_q == ST_WDATA || state_q == ST_RDATA))
                                    |=> ptr_q == $past(ptr_q) + 8'h01)
        else $error("Pointer not advanced");
    ro_ignore_a: assert property ((data_end && state_q == ST_WDATA && ptr_q < 8'h02)
                                  |=> $stable(cfg_q))
        else $error("Read-only write changed config");

    write_seen_c:  cover property (data_end && state_q == ST_WDATA && ptr_q == 8'h02);
    read_seen_c:   cover property (load_rd ##[1:1000] state_q == ST_RACK);
    flash_seen_c:  cover property ($rose(o_flash_on));

endmodule // flash_driver_config_regs
`default_nettype wire

/* File: flash_timeout_timer.sv */
// Flash timeout timer: ends a triggered flash after the coded duration
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg_regs.svh"
module flash_timeout_timer #(
    parameter int P_BASE_CYCLES = `TIMEOUT_BASE_CYCLES,
    parameter int P_STEP_CYCLES = `TIMEOUT_STEP_CYCLES
) (
    input  wire logic   i_clock,
    input  wire logic   i_rstn,
    flash_timer_if.timer tif
);
    import flash_cfg_pkg::*;

    logic [31:0] count_q, count_d;
    logic        on_q, on_d;
    logic        done_q, done_d;
    logic [31:0] limit;

    function automatic logic [31:0] timeout_cycles(input logic [3:0] code);
        timeout_cycles = 32'(P_BASE_CYCLES) + 32'(P_STEP_CYCLES) * {28'h0000000, code};
    endfunction

    assign limit = timeout_cycles(tif.timeout_code);

    always_comb begin
        count_d = count_q;
        on_d    = on_q;
        done_d  = done_q;
        if (!tif.trigger) begin
            count_d = 32'h00000000;
            on_d    = 1'b0;
            done_d  = 1'b0;
        end else if (!on_q && !done_q) begin
            count_d = 32'h00000001;
            on_d    = 1'b1;
        end else if (on_q) begin
            if (count_q >= limit) begin
                on_d   = 1'b0;
                done_d = 1'b1;
            end else begin
                count_d = count_q + 32'h00000001;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            count_q <= 32'h00000000;
            on_q    <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            on_q    <= on_d;
            done_q  <= done_d;
        end
    end

    assign tif.flash_on = on_q;
    assign tif.expired  = done_q;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    flash_bounded_a: assert property (on_q |-> count_q <= limit)
        else $error("Flash outlasted its timeout");
    flash_ends_a: assert property ((on_q && count_q >= limit && tif.trigger) |=> (!on_q && done_q))
        else $error("Flash not ended at timeout");
    timeout_seen_c: cover property (on_q && !on_d && tif.trigger);

endmodule // flash_timeout_timer
`default_nettype wire

/* File: flash_timer_if.sv */
// Link between the register bank and the flash timeout timer
`timescale 1ns/1ps
`default_nettype none
interface flash_timer_if;
    logic [3:0] timeout_code;
    logic       trigger;
    logic       flash_on;
    logic       expired;

    modport bank  (output timeout_code, output trigger, input flash_on, input expired);
    modport timer (input timeout_code, input trigger, output flash_on, output expired);
endinterface
`default_nettype wire

/* File: test_flash_driver_config_regs.sv */
// Self-checking testbench of the flash driver config register bank
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg_regs.svh"
module test_flash_driver_config_regs;
    localparam logic [7:0] ID_VAL  = 8'h5C; // Arbitrary value
    localparam logic [3:0] REV_VAL = 4'h3;  // Arbitrary value
    localparam int         BASE    = 20;
    localparam int         STEP    = 10;

    logic       clk = 1'b0;
    logic       rstn;
    logic       scl;
    logic       m_low;
    logic       sda_out;
    logic       sda_oe;
    logic       strobe;
    logic       req;
    logic       flash_on;
    logic       expired;
    logic [3:0] code_o;
    logic [1:0] thr_o;
    logic [1:0] ind_o;
    // Open-drain line: either side may only pull it low
    wire        sda = ~m_low & ~(sda_oe & ~sda_out);
    int         mismatches;
    int         n_compared;
    logic [7:0] cfg;
    logic [7:0] rnd;

    always #20 clk = ~clk;

    flash_driver_config_regs #(
        .P_TIMEOUT_BASE_CYCLES (BASE),
        .P_TIMEOUT_STEP_CYCLES (STEP),
        .P_CHIP_IDENTITY_VALUE (ID_VAL),
        .P_REVISION            (REV_VAL)
    ) dut_u (
        .i_clock (clk), .i_rstn (rstn), .i_scl (scl), .i_sda (sda),
        .o_sda_out (sda_out), .o_sda_oe (sda_oe), .i_strobe (strobe),
        .i_flash_request (req), .o_flash_on (flash_on), .o_flash_expired (expired),
        .o_flash_timeout_code (code_o), .o_led_count_threshold_voltage_sel (thr_o),
        .o_indicator_current_sel (ind_o)
    );

    two_wire_master_model m_u (.i_clock (clk), .i_sda (sda), .o_scl (scl), .o_sda_low (m_low));

    // ----------------------------------------
    // Reference model and checks
    // ----------------------------------------
    function automatic logic [7:0] model_read(input logic [7:0] a);
        case (a)
            8'h00:   return ID_VAL;
            8'h01:   return {4'h0, REV_VAL};
            8'h02:   return cfg;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_out();
        check({4'h0, code_o}, {4'h0, cfg[3:0]});
        check({6'h00, thr_o}, {6'h00, cfg[5:4]});
        check({6'h00, ind_o}, {6'h00, cfg[7:6]});
    endtask

    task automatic write_regs(input logic [7:0] ptr, input int n, input logic [7:0] d[3]);
        logic ack;
        m_u.start_cond();
        m_u.wbyte({`SLAVE_ADDRESS, 1'b0}, ack);
        check({7'h00, ack}, 8'h01);
        m_u.wbyte(ptr, ack);
        check({7'h00, ack}, 8'h01);
        for (int i = 0; i < n; i++) begin
            m_u.wbyte(d[i], ack);
            check({7'h00, ack}, 8'h01);
            if (8'(ptr + i) == 8'h02) cfg = d[i];
        end
        m_u.stop_cond();
        check_out();
    endtask

    task automatic read_regs(input logic [7:0] ptr, input int n);
        logic       ack;
        logic [7:0] got;
        m_u.start_cond();
        m_u.wbyte({`SLAVE_ADDRESS, 1'b0}, ack);
        m_u.wbyte(ptr, ack);
        m_u.start_cond();
        m_u.wbyte({`SLAVE_ADDRESS, 1'b1}, ack);
        check({7'h00, ack}, 8'h01);
        for (int i = 0; i < n; i++) begin
            m_u.rbyte(i < n - 1, got);
            check(got, model_read(8'(ptr + i)));
        end
        m_u.stop_cond();
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        final_report();
    end

    initial begin
        logic ack;
        int   cnt;
        int   exp;
        rstn = 1'b0; strobe = 1'b0; req = 1'b0;
        mismatches = 0; n_compared = 0; cfg = `CFG_RESET_VALUE; rnd = 8'h1E;
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        m_u.wait_clk(8);
        check_out();
        read_regs(8'h00, 4);
        m_u.start_cond();
        m_u.wbyte(8'h62, ack);
        check({7'h00, ack}, 8'h00);
        m_u.stop_cond();
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            write_regs(8'h02, 1, '{rnd, 8'h00, 8'h00});
            read_regs(8'h01, 2);
        end
        rnd = lfsr(rnd);
        write_regs(8'h00, 3, '{8'hFF, 8'hFF, rnd});
        read_regs(8'h00, 3);
        // Mid-run reset brings the config back to its defaults
        rstn = 1'b0;
        cfg = `CFG_RESET_VALUE;
        m_u.wait_clk(3);
        check_out();
        check({6'h00, sda_oe, flash_on}, 8'h00);
        rstn = 1'b1;
        m_u.wait_clk(8);
        check_out();
        read_regs(8'h02, 1);
        for (int s = 0; s < 2; s++) begin
            rnd = lfsr(rnd);
            write_regs(8'h02, 1, '{{rnd[7:4], 2'b00, rnd[1:0]}, 8'h00, 8'h00});
            exp = BASE + STEP * int'(rnd[1:0]);
            if (s == 0) req = 1'b1;
            else strobe = 1'b1;
            cnt = 0;
            for (int k = 0; k < 400 && !(cnt > 0 && flash_on === 1'b0); k++) begin
                m_u.wait_clk(1);
                if (flash_on === 1'b1) cnt++;
            end
            check(8'(cnt), 8'(exp));
            check({7'h00, expired}, 8'h01);
            req = 1'b0;
            strobe = 1'b0;
            m_u.wait_clk(10);
            check({6'h00, flash_on, expired}, 8'h00);
        end
        final_report();
    end
endmodule // test_flash_driver_config_regs
`default_nettype wire

/* File: two_wire_master_model.sv */
// Behavioural two-wire bus master that drives the serial clock and an open-drain data line
`timescale 1ns/1ps
`default_nettype none
module two_wire_master_model (
    input  wire logic i_clock,
    input  wire logic i_sda,
    output var logic  o_scl,
    output var logic  o_sda_low
);
    // Half of one serial clock period, in system clocks
    localparam int HALF = 12;

    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end

    // Moves just after a clock edge so the device never sees a race
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic start_cond();
        o_sda_low = 1'b0;
        wait_clk(HALF);
        o_scl = 1'b1;
        wait_clk(HALF);
        o_sda_low = 1'b1;
        wait_clk(HALF);
        o_scl = 1'b0;
        wait_clk(HALF);
    endtask

    task automatic stop_cond();
        o_sda_low = 1'b1;
        wait_clk(HALF);
        o_scl = 1'b1;
        wait_clk(HALF);
        o_sda_low = 1'b0;
        wait_clk(HALF);
    endtask

    // Data changes only while the clock is low; the line is sampled mid-high
    task automatic one_bit(input logic b, output logic r);
        o_sda_low = ~b;
        wait_clk(HALF);
        o_scl = 1'b1;
        wait_clk(HALF / 2);
        r = i_sda;
        wait_clk(HALF / 2);
        o_scl = 1'b0;
    endtask

    // MSB first, then a released ninth bit that the device pulls low to acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) one_bit(d[i], r);
        one_bit(1'b1, r);
        ack = ~r;
    endtask

    // Master acknowledges every byte but the last
    task automatic rbyte(input logic ack_in, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            one_bit(1'b1, r);
            d[i] = r;
        end
        one_bit(~ack_in, r);
    endtask
endmodule // two_wire_master_model
`default_nettype wire
